// [hdl/clpt_map.svh]
// Purpose: Offsets, field positions and reset values of the control list pointer tracker
// Assumes: Byte offsets from the controller base address, 8-bit offset decode
// Notes:   Definitions only
`ifndef CLPT_MAP_SVH
`define CLPT_MAP_SVH

// =====================================================================
// Register offsets
`define CLPT_OFF_CTRL_CUR   8'h24
`define CLPT_OFF_BULK_HEAD  8'h28

// =====================================================================
// Pointer field layout and reset values
`define CLPT_PTR_MSB        31
`define CLPT_PTR_LSB        4
`define CLPT_PTR_RST        28'h0000000
`define CLPT_PTR_END        28'h0000000
`define CLPT_RDATA_RST      32'h00000000

`endif

// [hdl/clpt_pkg.sv]
// Purpose: Types and shared helpers of the control list pointer tracker
// Assumes: Pointer fields are 28 bits wide, descriptors 16-byte aligned
// Notes:   Nothing here is imported; users write clpt_pkg::name
package clpt_pkg;

  // =====================================================================
  // Register access request, one per clock
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } clpt_req_t;

  // Pointer processor states, one-hot
  typedef enum logic [1:0] {
    CLPT_IDLE = 2'b01,
    CLPT_LOAD = 2'b10
  } clpt_state_t;

  // Widen a pointer field to a bus word; reserved low nibble reads zero
  function automatic logic [31:0] clpt_ptr_word(input logic [27:0] ptr);
    clpt_ptr_word = {ptr, 4'h0};
  endfunction : clpt_ptr_word

endpackage : clpt_pkg

// [hdl/clpt_rd_mux.sv]
// Purpose: Read data selection for the pointer registers
// Assumes: Offsets decoded on the full 8-bit offset
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "clpt_map.svh"

module clpt_rd_mux (
  input  wire logic [7:0]  addr_in,
  input  wire logic [27:0] ctrl_cur_in,
  input  wire logic [27:0] bulk_head_in,
  output logic      [31:0] rdata_out
);

  // =====================================================================
  // Offset decode; unmapped offsets read as zero
  always_comb begin
    case (addr_in)
      `CLPT_OFF_CTRL_CUR:  rdata_out = clpt_pkg::clpt_ptr_word(ctrl_cur_in);
      `CLPT_OFF_BULK_HEAD: rdata_out = clpt_pkg::clpt_ptr_word(bulk_head_in);
      default:             rdata_out = `CLPT_RDATA_RST;
    endcase
  end

endmodule : clpt_rd_mux

// [hdl/clpt_tracker.sv]
// Purpose: Holds and advances the control list current descriptor pointer, holds bulk head
// Assumes: List processor pulses ed_done_in once per served descriptor, with its link
// Notes:   Filled flag lives here; software sets it through clf_set_in, set beats clear
`timescale 1ns/1ps
`include "clpt_map.svh"

// Behaviour
// - after serving a descriptor, current pointer bits 31:4 step to the next one
// - a new frame resumes from the current pointer, never from the list head
// - at end of control list the filled flag is examined
// - flag set at end: load current from control head and clear the flag
// - flag clear at end: pointer and flag stay as they are
// - reset leaves the current pointer zero; zero marks end of control list
// - current register decodes at offset 24h, bits 3:0 reserved
// - bulk head register at offset 28h, read and write, reset zero
module clpt_tracker (
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  input  wire clpt_pkg::clpt_req_t  bus_req_in,
  output logic [31:0]               rdata_out,
  output logic                      rvalid_out,
  input  wire logic                 cle_in,
  input  wire logic                 clf_set_in,
  output logic                      clf_out,
  input  wire logic [31:0]          head_ptr_in,
  input  wire logic                 ed_done_in,
  input  wire logic [31:0]          next_ed_in,
  output logic [31:0]               cur_ptr_out,
  output logic                      list_end_out
);

  // =====================================================================
  // State
  clpt_pkg::clpt_state_t state_q;
  clpt_pkg::clpt_state_t state_d;
  logic [27:0]           cur_q;
  logic [27:0]           cur_d;
  logic [27:0]           bhead_q;
  logic [27:0]           bhead_d;
  logic                  clf_q;
  logic                  clf_d;
  logic [31:0]           rdata_q;
  logic [31:0]           rdata_d;
  logic                  rvalid_q;
  logic                  rvalid_d;
  logic                  end_q;
  logic                  end_d;
  logic                  at_end;
  logic                  wr_cur;
  logic                  wr_bhead;
  logic [31:0]           mux_word;

  // Zero pointer is the end of the control list
  assign at_end   = (cur_q == `CLPT_PTR_END);
  assign wr_cur   = bus_req_in.wr && (bus_req_in.addr == `CLPT_OFF_CTRL_CUR);
  assign wr_bhead = bus_req_in.wr && (bus_req_in.addr == `CLPT_OFF_BULK_HEAD);

  // =====================================================================
  // Pointer processor: advance, end-of-list check, head reload
  always_comb begin
    state_d = state_q;
    cur_d   = cur_q;
    clf_d   = clf_q;
    case (state_q)
      clpt_pkg::CLPT_IDLE: begin
        if (cle_in && at_end && clf_q) begin
          state_d = clpt_pkg::CLPT_LOAD;
        end else if (cle_in && ed_done_in && !at_end) begin
          cur_d = next_ed_in[`CLPT_PTR_MSB:`CLPT_PTR_LSB];
        end else if (wr_cur && !cle_in) begin
          // Enabled list owns the pointer; late software writes are dropped
          cur_d = bus_req_in.wdata[`CLPT_PTR_MSB:`CLPT_PTR_LSB];
        end
      end
      clpt_pkg::CLPT_LOAD: begin
        cur_d   = head_ptr_in[`CLPT_PTR_MSB:`CLPT_PTR_LSB];
        clf_d   = 1'b0;
        state_d = clpt_pkg::CLPT_IDLE;
      end
      default: begin
        state_d = clpt_pkg::CLPT_IDLE;
      end
    endcase
    // Software setting the flag in the clearing cycle must not be lost
    if (clf_set_in) begin
      clf_d = 1'b1;
    end
  end

  // No frame hook: the pointer simply persists between frames
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_q <= clpt_pkg::CLPT_IDLE;
      cur_q   <= `CLPT_PTR_RST;
      clf_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cur_q   <= cur_d;
      clf_q   <= clf_d;
    end
  end

  // =====================================================================
  // Bulk head register, always writable
  always_comb begin
    bhead_d = bhead_q;
    if (wr_bhead) begin
      bhead_d = bus_req_in.wdata[`CLPT_PTR_MSB:`CLPT_PTR_LSB];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      bhead_q <= `CLPT_PTR_RST;
    end else begin
      bhead_q <= bhead_d;
    end
  end

  // =====================================================================
  // Read path: sample the live registers, answer one cycle later
  clpt_rd_mux u_rd_mux (
    .addr_in      (bus_req_in.addr),
    .ctrl_cur_in  (cur_q),
    .bulk_head_in (bhead_q),
    .rdata_out    (mux_word)
  );

  always_comb begin
    rvalid_d = bus_req_in.rd;
    rdata_d  = bus_req_in.rd ? mux_word : `CLPT_RDATA_RST;
    end_d    = (cur_d == `CLPT_PTR_END);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_q  <= `CLPT_RDATA_RST;
      rvalid_q <= 1'b0;
      end_q    <= 1'b1;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      end_q    <= end_d;
    end
  end

  // Outputs straight from flops
  assign rdata_out    = rdata_q;
  assign rvalid_out   = rvalid_q;
  assign clf_out      = clf_q;
  assign cur_ptr_out  = clpt_pkg::clpt_ptr_word(cur_q);
  assign list_end_out = end_q;

  // =====================================================================
  // Assertions
  a_step_next_ed: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == clpt_pkg::CLPT_IDLE) && cle_in && ed_done_in && !at_end
    |=> cur_q == $past(next_ed_in[31:4]))
    else $error("pointer did not step to next descriptor");

  a_end_check: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == clpt_pkg::CLPT_IDLE) && cle_in && at_end && clf_q
    |=> state_q == clpt_pkg::CLPT_LOAD)
    else $error("filled flag not acted on at list end");

  a_head_reload: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == clpt_pkg::CLPT_LOAD) && !clf_set_in
    |=> (cur_q == $past(head_ptr_in[31:4])) && !clf_q)
    else $error("head reload or flag clear missing");

  a_end_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == clpt_pkg::CLPT_IDLE) && cle_in && at_end && !clf_q && !clf_set_in
    |=> at_end && !clf_q && (state_q == clpt_pkg::CLPT_IDLE))
    else $error("list end changed state without filled flag");

  a_wr_blocked: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == clpt_pkg::CLPT_IDLE) && wr_cur && cle_in && !ed_done_in
    |=> $stable(cur_q))
    else $error("pointer written while list enabled");

  a_reset_zero: assert property (@(posedge clk_in)
    !nrst_in |=> (cur_q == 28'h0000000) && (bhead_q == 28'h0000000) && list_end_out)
    else $error("pointers not zero after reset");

  a_cur_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    bus_req_in.rd && (bus_req_in.addr == 8'h24)
    |=> rvalid_out && (rdata_out == {$past(cur_q), 4'h0}))
    else $error("current register read wrong");

  a_bulk_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    wr_bhead |=> bhead_q == $past(bus_req_in.wdata[31:4]))
    else $error("bulk head write lost");

  a_rsv_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rvalid_out |-> (rdata_out[3:0] == 4'h0) && (cur_ptr_out[3:0] == 4'h0))
    else $error("reserved bits not zero");

  // Pointer persists across frames; only a served descriptor, a write or a reload moves it
  a_frame_resume: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == clpt_pkg::CLPT_IDLE) && !ed_done_in && !wr_cur
    && !(cle_in && at_end && clf_q) |=> $stable(cur_q))
    else $error("pointer moved with no descriptor event");

  // Disabled list: the processor has no say over the pointer
  a_off_no_step: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == clpt_pkg::CLPT_IDLE) && !cle_in && ed_done_in && !wr_cur
    |=> $stable(cur_q))
    else $error("pointer stepped while list disabled");

  // Software set must survive a reload clear in the same cycle
  a_set_wins: assert property (@(posedge clk_in) disable iff (!nrst_in)
    clf_set_in |=> clf_out)
    else $error("filled flag set was lost");

  // Reload is a single cycle, so the list processor is never stalled for long
  a_load_once: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == clpt_pkg::CLPT_LOAD) |=> (state_q == clpt_pkg::CLPT_IDLE))
    else $error("reload lasted more than one cycle");

  // End flag is registered from the next pointer, so it must track the pointer flop
  a_end_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
    list_end_out == (cur_q == 28'h0000000))
    else $error("list end flag disagrees with pointer");

  // Read answer only follows a read; idle bus shows zero data
  a_rd_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !bus_req_in.rd |=> !rvalid_out && (rdata_out == 32'h00000000))
    else $error("read answer without a read");

endmodule : clpt_tracker

// [bench/test_control_list_pointer_tracker.sv]
// Purpose: Self-checking bench of the control list pointer tracker
// Assumes: Inputs change on the falling edge; read data is checked the cycle after the request
// Notes:   Plain register cases run from a table; list walking and reload are hand-written
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_control_list_pointer_tracker;
  // ==========================================================================
  // Stimulus and observed signals
  typedef struct {logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp;} clpt_row_t;
  logic                clk_in      = 1'b0;
  logic                nrst_in     = 1'b0;
  clpt_pkg::clpt_req_t req         = '0;
  logic                cle_in      = 1'b0;
  logic                clf_set_in  = 1'b0;
  logic [31:0]         head_ptr_in = 32'h00000000;
  logic                ed_done_in  = 1'b0;
  logic [31:0]         next_ed_in  = 32'h00000000;
  logic [31:0]         rdata_out;
  logic                rvalid_out;
  logic                clf_out;
  logic [31:0]         cur_ptr_out;
  logic                list_end_out;
  int                  n_fail      = 0;
  int                  tests_run   = 0;
  int                  cycles      = 0;
  clpt_row_t           rows [4]    = '{'{8'h24, 32'h12345678, 32'h12345670},
                                       '{8'h28, 32'hFFFFFFFF, 32'hFFFFFFF0},
                                       '{8'h2C, 32'hDEADBEEF, 32'h00000000},
                                       '{8'h28, 32'h0000001F, 32'h00000010}};

  clpt_tracker u_clpt_tracker (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .bus_req_in   (req),
    .rdata_out    (rdata_out),
    .rvalid_out   (rvalid_out),
    .cle_in       (cle_in),
    .clf_set_in   (clf_set_in),
    .clf_out      (clf_out),
    .head_ptr_in  (head_ptr_in),
    .ed_done_in   (ed_done_in),
    .next_ed_in   (next_ed_in),
    .cur_ptr_out  (cur_ptr_out),
    .list_end_out (list_end_out)
  );

  // ==========================================================================
  // Clock and hang guard; the whole run needs well under a thousand cycles
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================================================
  // Bus cycles: one idle cycle between accesses keeps strobes from merging
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_in);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge clk_in);
    req.wr    = 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk_in);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge clk_in);
    req.rd   = 1'b0;
    `CHK(rvalid_out, 1'b1)
    `CHK(rdata_out, e)
  endtask : bus_rd

  // One served descriptor; pointer must follow the link with the low nibble cleared
  task automatic serve(input logic [31:0] nx);
    @(negedge clk_in);
    ed_done_in = 1'b1;
    next_ed_in = nx;
    @(negedge clk_in);
    ed_done_in = 1'b0;
    next_ed_in = ~nx;
    `CHK(cur_ptr_out, {nx[31:4], 4'h0})
    `CHK(list_end_out, (nx[31:4] == 28'h0000000))
  endtask : serve

  task automatic complete_run();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(negedge clk_in);
    nrst_in = 1'b1;
    `CHK(cur_ptr_out, 32'h00000000)
    bus_rd(8'h24, 32'h00000000);
    bus_rd(8'h28, 32'h00000000);
    $display("test reset done");
    // Table of writes with list disabled, each followed by a read-back
    foreach (rows[i]) begin
      bus_wr(rows[i].addr, rows[i].wdata);
      bus_rd(rows[i].addr, rows[i].exp);
    end
    $display("test register table done");
    // Enabled list: software write must not land, reads show the live pointer
    cle_in = 1'b1;
    bus_wr(8'h24, 32'h55555555);
    bus_rd(8'h24, 32'h12345670);
    serve(32'h00001238);
    serve(32'h0000ABCF);
    bus_rd(8'h24, 32'h0000ABC0);
    // Pause between frames must not rewind the pointer to the head
    cle_in = 1'b0;
    repeat (4) @(negedge clk_in);
    cle_in = 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK(cur_ptr_out, 32'h0000ABC0)
    $display("test walk done");
    // End of list with the flag clear: nothing moves
    head_ptr_in = 32'h0ABCDEF7;
    serve(32'h0000000C);
    repeat (4) @(negedge clk_in);
    `CHK(cur_ptr_out, 32'h00000000)
    `CHK(clf_out, 1'b0)
    // Flag raised at end of list: reload from head and clear the flag
    @(negedge clk_in);
    clf_set_in = 1'b1;
    @(negedge clk_in);
    clf_set_in = 1'b0;
    `CHK(clf_out, 1'b1)
    repeat (3) @(negedge clk_in);
    `CHK(cur_ptr_out, 32'h0ABCDEF0)
    `CHK(clf_out, 1'b0)
    `CHK(list_end_out, 1'b0)
    $display("test end of list done");
    // Second reset in mid-run
    nrst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    nrst_in = 1'b1;
    `CHK(cur_ptr_out, 32'h00000000)
    `CHK(list_end_out, 1'b1)
    bus_rd(8'h28, 32'h00000000);
    $display("test second reset done");
    // Awkward: a served descriptor at list end is refused, pointer stays zero
    @(negedge clk_in);
    ed_done_in = 1'b1;
    next_ed_in = 32'h00001230;
    @(negedge clk_in);
    ed_done_in = 1'b0;
    `CHK(cur_ptr_out, 32'h00000000)
    `CHK(list_end_out, 1'b1)
    // Awkward: flag set held across the reload cycle; the set beats the clear
    @(negedge clk_in);
    clf_set_in = 1'b1;
    repeat (3) @(negedge clk_in);
    clf_set_in = 1'b0;
    `CHK(cur_ptr_out, 32'h0ABCDEF0)
    `CHK(clf_out, 1'b1)
    // Awkward: read and write of the current register in one cycle, old value returned
    cle_in = 1'b0;
    @(negedge clk_in);
    req.rd    = 1'b1;
    req.wr    = 1'b1;
    req.addr  = 8'h24;
    req.wdata = 32'h00000A5F;
    @(negedge clk_in);
    req.rd    = 1'b0;
    req.wr    = 1'b0;
    `CHK(rvalid_out, 1'b1)
    `CHK(rdata_out, 32'h0ABCDEF0)
    bus_rd(8'h24, 32'h00000A50);
    // Awkward: a served descriptor while the list is disabled moves nothing
    @(negedge clk_in);
    ed_done_in = 1'b1;
    next_ed_in = 32'h00000B60;
    @(negedge clk_in);
    ed_done_in = 1'b0;
    `CHK(cur_ptr_out, 32'h00000A50)
    $display("test awkward cases done");
    complete_run();
  end
endmodule : test_control_list_pointer_tracker
